/* File: core/tsp_pkg.sv */
package tsp_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_RATE     = 8'h4c;
  localparam logic [7:0] IDX_S0_HIGH  = 8'h4d;
  localparam logic [7:0] IDX_S0_LOW   = 8'h4e;
  localparam logic [7:0] IDX_S1_HIGH  = 8'h4f;
  localparam logic [7:0] IDX_S1_LOW   = 8'h50;
  localparam logic [7:0] IDX_S2       = 8'h51;
  localparam logic [7:0] IDX_S3       = 8'h52;
  localparam logic [7:0] IDX_LEN_LONG = 8'h53;
  localparam logic [7:0] IDX_LEN_SHRT = 8'h54;
  localparam logic [7:0] IDX_ENV_LO   = 8'h56;

  // Bus geometry
  localparam int         ADDR_W      = 12;
  localparam int         IDX_LSB     = 2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Values after reset
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_ENV  = 3'h0;

  // Field positions and masks
  localparam int         HI_SC_BIT    = 7;
  localparam int         HI_RATE_LSB  = 4;
  localparam int         LO_SC_BIT    = 3;
  localparam int         LO_RATE_LSB  = 0;
  localparam int         LEN_HI_LSB   = 4;
  localparam logic [7:0] LEN_SHRT_MSK = 8'h77;
  localparam logic [2:0] RATE_MIN     = 3'h2;
  localparam logic [2:0] RATE_TOP     = 3'h7;
  localparam logic [2:0] ENV_LAST     = 3'h5;

  // Bit timing: fastest rate is the carrier over sixteen
  localparam int CLK_KHZ      = 200000;
  localparam int CARRIER_KHZ  = 13560;
  localparam int DIV_FASTEST  = 16;
  localparam int BIT_CYC_FAST = CLK_KHZ * DIV_FASTEST / CARRIER_KHZ;

  // Request into the shifter
  typedef struct packed {
    logic [15:0] pattern;
    logic [4:0]  nbits;
    logic [12:0] period;
  } tsp_ser_req_t;

  // Symbol output toward the modulator
  typedef struct packed {
    logic       bit_valid;
    logic       bit_data;
    logic       subcarrier_848;
    logic [2:0] envelope;
    logic [1:0] symbol;
  } tsp_tx_t;

  typedef enum logic [1:0] {
    SER_IDLE  = 2'b00,
    SER_SHIFT = 2'b01,
    SER_DONE  = 2'b11
  } tsp_ser_state_t;

  typedef struct packed {
    tsp_ser_state_t state;
    logic [15:0]    sreg;
    logic [4:0]     left;
    logic [12:0]    tmr;
    logic [12:0]    period;
  } tsp_ser_st_t;

  typedef struct packed {
    logic       aw_got;
    logic [7:0] aw_idx;
    logic       aw_hi;
    logic       w_got;
    logic [7:0] w_byte;
    logic       w_en;
    logic       bvalid;
    logic [1:0] bresp;
    logic       rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic [7:0] rate;
    logic [7:0] s0_hi;
    logic [7:0] s0_lo;
    logic [7:0] s1_hi;
    logic [7:0] s1_lo;
    logic [7:0] s2;
    logic [7:0] s3;
    logic [7:0] len_long;
    logic [7:0] len_shrt;
    logic [2:0] env_lo;
    logic       tx_sc;
    logic [2:0] tx_env;
    logic [1:0] tx_sym;
    logic       reject;
  } tsp_st_t;

endpackage : tsp_pkg

/* File: core/tsp_symbol_shifter.sv */
module tsp_symbol_shifter (
  // Clock, reset, enable
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  ce,
  // Load request
  input  wire logic                  start,
  input  wire tsp_pkg::tsp_ser_req_t req,
  // Serial output
  output logic                       busy,
  output logic                       bit_valid,
  output logic                       bit_data,
  output logic                       done
);

  tsp_pkg::tsp_ser_st_t st_reg;
  tsp_pkg::tsp_ser_st_t st_next;

  // Shift out left-justified pattern, one bit per period
  always_comb begin
    st_next = st_reg;
    case (st_reg.state)
      tsp_pkg::SER_IDLE: begin
        if (start) begin
          st_next.state  = tsp_pkg::SER_SHIFT;
          st_next.sreg   = req.pattern;
          st_next.left   = req.nbits;
          st_next.period = req.period;
          st_next.tmr    = 13'(req.period - 13'h1);
        end
      end
      tsp_pkg::SER_SHIFT: begin
        if (st_reg.tmr == 13'h0) begin
          if (st_reg.left == 5'h1) begin
            st_next.state = tsp_pkg::SER_DONE;
          end else begin
            st_next.sreg = {st_reg.sreg[14:0], 1'b0};
            st_next.left = 5'(st_reg.left - 5'h1);
            st_next.tmr  = 13'(st_reg.period - 13'h1);
          end
        end else begin
          st_next.tmr = 13'(st_reg.tmr - 13'h1);
        end
      end
      tsp_pkg::SER_DONE: begin
        st_next.state = tsp_pkg::SER_IDLE;
      end
      default: begin
        st_next.state = tsp_pkg::SER_IDLE;
      end
    endcase
  end

  // State register, frozen while ce is low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // Outputs decoded from state
  assign busy      = (st_reg.state != tsp_pkg::SER_IDLE);
  assign bit_valid = (st_reg.state == tsp_pkg::SER_SHIFT);
  assign bit_data  = st_reg.sreg[15];
  assign done      = (st_reg.state == tsp_pkg::SER_DONE);

endmodule : tsp_symbol_shifter

/* File: core/tsp_symbol_config.sv */
// Added by the designer: register access over AXI4-Lite.
module tsp_symbol_config #(
  parameter logic [12:0] BIT_CYC_FAST = 13'(tsp_pkg::BIT_CYC_FAST)
) (
  // Clock, reset, enable
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic                        ce,
  // AXI4-Lite write address
  input  wire logic [tsp_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic [2:0]                  s_axi_awprot,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [tsp_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic [2:0]                  s_axi_arprot,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  // Symbol request from the encoder
  input  wire logic                        sym_start,
  input  wire logic [1:0]                  sym_sel,
  output logic                             sym_busy,
  output logic                             sym_done,
  output logic                             sym_reject,
  // Symbol stream toward the modulator
  output tsp_pkg::tsp_tx_t                 tx
);

  tsp_pkg::tsp_st_t      st_reg;
  tsp_pkg::tsp_st_t      st_next;
  tsp_pkg::tsp_ser_req_t ser_req;
  logic                  ser_start;
  logic                  ser_busy;
  logic                  ser_valid;
  logic                  ser_data;
  logic                  ser_done;
  logic [2:0]            rate_code;
  logic                  accept;

  // Register index and range check of a bus address
  function automatic logic [8:0] decode(input logic [tsp_pkg::ADDR_W-1:0] a);
    logic hi;
    hi = (a[tsp_pkg::ADDR_W-1:tsp_pkg::IDX_LSB+8] != '0);
    return {hi, a[tsp_pkg::IDX_LSB+7:tsp_pkg::IDX_LSB]};
  endfunction : decode

  // Bit period in cycles for a rate code
  function automatic logic [12:0] bit_period(input logic [2:0] code);
    return 13'(BIT_CYC_FAST << (tsp_pkg::RATE_TOP - code));
  endfunction : bit_period

  // Handshake readies, held off while frozen
  assign s_axi_awready = ce && !st_reg.aw_got && !st_reg.bvalid;
  assign s_axi_wready  = ce && !st_reg.w_got && !st_reg.bvalid;
  assign s_axi_arready = ce && !st_reg.rvalid;

  // Rate code and pattern for the requested symbol
  always_comb begin
    ser_req = '0;
    case (sym_sel)
      2'h0: begin
        rate_code      = st_reg.rate[tsp_pkg::LO_RATE_LSB+:3];
        ser_req.nbits  = 5'(st_reg.len_long[3:0]) + 5'h1;
        // upper byte first, valid bits leading
        ser_req.pattern = 16'({st_reg.s0_hi, st_reg.s0_lo} << (5'h10 - ser_req.nbits));
      end
      2'h1: begin
        rate_code      = st_reg.rate[tsp_pkg::LO_RATE_LSB+:3];
        ser_req.nbits  = 5'(st_reg.len_long[tsp_pkg::LEN_HI_LSB+:4]) + 5'h1;
        // upper byte first, valid bits leading
        ser_req.pattern = 16'({st_reg.s1_hi, st_reg.s1_lo} << (5'h10 - ser_req.nbits));
      end
      2'h2: begin
        rate_code      = st_reg.rate[tsp_pkg::HI_RATE_LSB+:3];
        ser_req.nbits  = 5'(st_reg.len_shrt[2:0]) + 5'h1;
        ser_req.pattern = 16'({st_reg.s2, 8'h00} << (5'h08 - ser_req.nbits));
      end
      default: begin
        rate_code      = st_reg.rate[tsp_pkg::HI_RATE_LSB+:3];
        ser_req.nbits  = 5'(st_reg.len_shrt[tsp_pkg::LEN_HI_LSB+:3]) + 5'h1;
        ser_req.pattern = 16'({st_reg.s3, 8'h00} << (5'h08 - ser_req.nbits));
      end
    endcase
    // bit clocked at the pair's rate
    ser_req.period = bit_period(rate_code);
  end

  // reserved rate codes refuse the symbol
  assign accept    = sym_start && !ser_busy && (rate_code >= tsp_pkg::RATE_MIN);
  assign ser_start = accept;

  // Bus slave, register writes and symbol bookkeeping
  always_comb begin
    logic [8:0] wdec;
    logic [8:0] rdec;
    logic [7:0] rbyte;
    logic       rok;
    st_next = st_reg;
    wdec    = {st_reg.aw_hi, st_reg.aw_idx};
    rdec    = decode(s_axi_araddr);
    rbyte   = 8'h00;
    rok     = 1'b0;
    // Capture address and data in either order
    if (s_axi_awvalid && s_axi_awready) begin
      st_next.aw_got = 1'b1;
      {st_next.aw_hi, st_next.aw_idx} = decode(s_axi_awaddr);
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_next.w_got  = 1'b1;
      st_next.w_byte = s_axi_wdata[7:0];
      st_next.w_en   = s_axi_wstrb[0];
    end
    // Perform write once both halves are held
    if (st_reg.aw_got && st_reg.w_got) begin
      st_next.aw_got = 1'b0;
      st_next.w_got  = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp  = tsp_pkg::RESP_OKAY;
      if (wdec[8]) begin
        st_next.bresp = tsp_pkg::RESP_SLVERR;
      end else if (wdec[7:0] == tsp_pkg::IDX_RATE) begin
        if (st_reg.w_en) st_next.rate = st_reg.w_byte;
      end else if (wdec[7:0] == tsp_pkg::IDX_S0_HIGH) begin
        if (st_reg.w_en) st_next.s0_hi = st_reg.w_byte;
      end else if (wdec[7:0] == tsp_pkg::IDX_S0_LOW) begin
        if (st_reg.w_en) st_next.s0_lo = st_reg.w_byte;
      end else if (wdec[7:0] == tsp_pkg::IDX_S1_HIGH) begin
        if (st_reg.w_en) st_next.s1_hi = st_reg.w_byte;
      end else if (wdec[7:0] == tsp_pkg::IDX_S1_LOW) begin
        if (st_reg.w_en) st_next.s1_lo = st_reg.w_byte;
      end else if (wdec[7:0] == tsp_pkg::IDX_S2) begin
        if (st_reg.w_en) st_next.s2 = st_reg.w_byte;
      end else if (wdec[7:0] == tsp_pkg::IDX_S3) begin
        if (st_reg.w_en) st_next.s3 = st_reg.w_byte;
      end else if (wdec[7:0] == tsp_pkg::IDX_LEN_LONG) begin
        if (st_reg.w_en) st_next.len_long = st_reg.w_byte;
      end else if (wdec[7:0] == tsp_pkg::IDX_LEN_SHRT) begin
        if (st_reg.w_en) st_next.len_shrt = st_reg.w_byte & tsp_pkg::LEN_SHRT_MSK;
      end else if (wdec[7:0] == tsp_pkg::IDX_ENV_LO) begin
        if (st_reg.w_en) st_next.env_lo = st_reg.w_byte[2:0];
      end else begin
        st_next.bresp = tsp_pkg::RESP_SLVERR;
      end
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    // Read decode
    if (rdec[8]) begin
      rok = 1'b0;
    end else if (rdec[7:0] == tsp_pkg::IDX_RATE) begin
      rbyte = st_reg.rate;
      rok   = 1'b1;
    end else if (rdec[7:0] == tsp_pkg::IDX_S0_HIGH) begin
      rbyte = st_reg.s0_hi;
      rok   = 1'b1;
    end else if (rdec[7:0] == tsp_pkg::IDX_S0_LOW) begin
      rbyte = st_reg.s0_lo;
      rok   = 1'b1;
    end else if (rdec[7:0] == tsp_pkg::IDX_S1_HIGH) begin
      rbyte = st_reg.s1_hi;
      rok   = 1'b1;
    end else if (rdec[7:0] == tsp_pkg::IDX_S1_LOW) begin
      rbyte = st_reg.s1_lo;
      rok   = 1'b1;
    end else if (rdec[7:0] == tsp_pkg::IDX_S2) begin
      rbyte = st_reg.s2;
      rok   = 1'b1;
    end else if (rdec[7:0] == tsp_pkg::IDX_S3) begin
      rbyte = st_reg.s3;
      rok   = 1'b1;
    end else if (rdec[7:0] == tsp_pkg::IDX_LEN_LONG) begin
      rbyte = st_reg.len_long;
      rok   = 1'b1;
    end else if (rdec[7:0] == tsp_pkg::IDX_LEN_SHRT) begin
      rbyte = st_reg.len_shrt & tsp_pkg::LEN_SHRT_MSK;
      rok   = 1'b1;
    end else if (rdec[7:0] == tsp_pkg::IDX_ENV_LO) begin
      rbyte = {5'h00, st_reg.env_lo};
      rok   = 1'b1;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      st_next.rvalid = 1'b1;
      st_next.rdata  = rbyte;
      st_next.rresp  = rok ? tsp_pkg::RESP_OKAY : tsp_pkg::RESP_SLVERR;
    end else if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    // Latch per-symbol settings at the accepted start
    st_next.reject = sym_start && !accept;
    if (accept) begin
      st_next.tx_sym = sym_sel;
      if (sym_sel[1]) begin
        st_next.tx_sc  = st_reg.rate[tsp_pkg::HI_SC_BIT];
        st_next.tx_env = tsp_pkg::RST_ENV;
      end else begin
        st_next.tx_sc  = st_reg.rate[tsp_pkg::LO_SC_BIT];
        // envelope, unused codes fall back to direct
        st_next.tx_env = (st_reg.env_lo > tsp_pkg::ENV_LAST) ? tsp_pkg::RST_ENV
                                                             : st_reg.env_lo;
      end
    end
  end

  // State register, frozen while ce is low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '{rate: tsp_pkg::RST_BYTE, s0_hi: tsp_pkg::RST_BYTE,
                  s0_lo: tsp_pkg::RST_BYTE, s1_hi: tsp_pkg::RST_BYTE,
                  s1_lo: tsp_pkg::RST_BYTE, s2: tsp_pkg::RST_BYTE,
                  s3: tsp_pkg::RST_BYTE, len_long: tsp_pkg::RST_BYTE,
                  len_shrt: tsp_pkg::RST_BYTE, env_lo: tsp_pkg::RST_ENV,
                  tx_env: tsp_pkg::RST_ENV, default: '0};
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  tsp_symbol_shifter u_shifter (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .ce        (ce),
    .start     (ser_start),
    .req       (ser_req),
    .busy      (ser_busy),
    .bit_valid (ser_valid),
    .bit_data  (ser_data),
    .done      (ser_done)
  );

  // Bus answers from registers
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp  = st_reg.bresp;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata  = {24'h000000, st_reg.rdata};
  assign s_axi_rresp  = st_reg.rresp;

  // Symbol status and stream
  assign sym_busy          = ser_busy;
  assign sym_done          = ser_done;
  assign sym_reject        = st_reg.reject;
  assign tx.bit_valid      = ser_valid;
  assign tx.bit_data       = ser_data;
  assign tx.subcarrier_848 = st_reg.tx_sc;
  assign tx.envelope       = st_reg.tx_env;
  assign tx.symbol         = st_reg.tx_sym;

endmodule : tsp_symbol_config

/* File: dv/tsp_symbol_config_assertions.sv */
module tsp_symbol_config_assertions (
  // Clock and reset
  input wire logic             aclk,
  input wire logic             aresetn,
  // Register bus handshakes
  input wire logic             s_axi_awvalid,
  input wire logic             s_axi_awready,
  input wire logic             s_axi_wvalid,
  input wire logic             s_axi_wready,
  input wire logic             s_axi_bvalid,
  input wire logic             s_axi_bready,
  input wire logic             s_axi_arvalid,
  input wire logic             s_axi_arready,
  input wire logic [31:0]      s_axi_rdata,
  input wire logic             s_axi_rvalid,
  input wire logic             s_axi_rready,
  // Symbol port
  input wire logic             sym_start,
  input wire logic             sym_busy,
  input wire logic             sym_done,
  input wire logic             sym_reject,
  input wire tsp_pkg::tsp_tx_t tx
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Bus answers and holding
  property p_rd_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  property p_wr_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  property p_rd_zero;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  // Symbol stream framing
  property p_first_bit;
    $rose(tx.bit_valid) |-> $past(sym_start) && !$past(sym_busy);
  endproperty
  property p_busy_rej;
    sym_start && sym_busy |=> sym_reject && !$rose(tx.bit_valid);
  endproperty
  property p_done;
    sym_done |-> $past(tx.bit_valid) && !tx.bit_valid && sym_busy ##1 !sym_busy;
  endproperty
  property p_latch;
    tx.bit_valid && $past(tx.bit_valid) |->
      $stable(tx.subcarrier_848) && $stable(tx.envelope) && $stable(tx.symbol);
  endproperty
  property p_env_hi;
    tx.bit_valid && tx.symbol[1] |-> tx.envelope == 3'h0;
  endproperty

  a_rd_lat:    assert property (p_rd_lat) else $error("read answer late");
  a_wr_lat:    assert property (p_wr_lat) else $error("write answer late");
  a_r_hold:    assert property (p_r_hold) else $error("read data dropped");
  a_b_hold:    assert property (p_b_hold) else $error("write response dropped");
  a_rd_zero:   assert property (p_rd_zero) else $error("read upper bits set");
  a_first_bit: assert property (p_first_bit) else $error("bit without start");
  a_busy_rej:  assert property (p_busy_rej) else $error("busy start not refused");
  a_done:      assert property (p_done) else $error("done pulse misplaced");
  a_latch:     assert property (p_latch) else $error("frequency moved mid symbol");
  a_env_hi:    assert property (p_env_hi) else $error("envelope on short symbol");

  // Main scenarios reached
  c_write:  cover property (s_axi_bvalid && s_axi_bready);
  c_done:   cover property (sym_done);
  c_reject: cover property (sym_reject);
endmodule : tsp_symbol_config_assertions

/* File: dv/tsp_modulator_model.sv */
module tsp_modulator_model (
  // Clock and reset
  input wire logic             aclk,
  input wire logic             aresetn,
  // Symbol stream and expected bit period
  input wire tsp_pkg::tsp_tx_t tx,
  input wire logic [12:0]      per,
  // Captured symbol
  output logic [15:0]          bits,
  output logic [4:0]           nbits,
  output logic [15:0]          cyc,
  output logic [7:0]           glitch
);
  logic was_on;

  // Take a bit at each period start, count mid-bit changes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      was_on <= 1'b0;
      bits   <= 16'h0;
      nbits  <= 5'h0;
      cyc    <= 16'h0;
      glitch <= 8'h0;
    end else begin
      was_on <= tx.bit_valid;
      if (tx.bit_valid && !was_on) begin
        bits  <= {15'h0, tx.bit_data};
        nbits <= 5'h1;
        cyc   <= 16'h1;
      end else if (tx.bit_valid) begin
        cyc <= cyc + 16'h1;
        if (cyc % {3'h0, per} == 16'h0) begin
          bits  <= {bits[14:0], tx.bit_data};
          nbits <= nbits + 5'h1;
        end else if (tx.bit_data !== bits[0])
          glitch <= glitch + 8'h1;
      end
    end
  end
endmodule : tsp_modulator_model

/* File: dv/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [12:0] BCF = 13'h4;

  logic             aclk, aresetn, sym_start, sym_busy, sym_done, sym_reject;
  logic [11:0]      s_axi_awaddr, s_axi_araddr;
  logic [31:0]      s_axi_wdata, s_axi_rdata;
  logic [3:0]       s_axi_wstrb;
  logic [1:0]       s_axi_bresp, s_axi_rresp, sym_sel;
  logic             s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic             s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic             s_axi_rvalid, s_axi_rready, late;
  tsp_pkg::tsp_tx_t tx;
  logic [12:0]      per;
  logic [15:0]      m_bits, m_cyc;
  logic [4:0]       m_n;
  logic [7:0]       m_gl;
  int               n_fail, checked, cycles;
  logic [7:0] idx [10] = '{tsp_pkg::IDX_RATE, tsp_pkg::IDX_S0_HIGH, tsp_pkg::IDX_S0_LOW,
    tsp_pkg::IDX_S1_HIGH, tsp_pkg::IDX_S1_LOW, tsp_pkg::IDX_S2, tsp_pkg::IDX_S3,
    tsp_pkg::IDX_LEN_LONG, tsp_pkg::IDX_LEN_SHRT, tsp_pkg::IDX_ENV_LO};
  logic [7:0] msk [10] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h77, 8'h07};
  logic [7:0] cfg [10] = '{8'he7, 8'ha5, 8'h3c, 8'h81, 8'hf0, 8'hc6, 8'h5a, 8'h0f, 8'hba, 8'h05};

  // Design and far-side receiver
  tsp_symbol_config #(.BIT_CYC_FAST(BCF)) dut_u (.aclk, .aresetn, .ce(1'b1),
    .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sym_start, .sym_sel, .sym_busy, .sym_done,
    .sym_reject, .tx);
  tsp_modulator_model mdl_u (.aclk, .aresetn, .tx, .per, .bits(m_bits), .nbits(m_n),
    .cyc(m_cyc), .glitch(m_gl));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic test_done();
    if (n_fail == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done

  task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [1:0] er);
    logic [3:0] hs;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_awaddr  <= {2'h0, i, 2'h0};
    s_axi_wdata   <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= !late;
    hs = 4'h0;
    // Late mode raises bready only once the response is seen waiting
    while (!hs[0]) begin
      @(negedge aclk);
      hs = {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready, s_axi_bvalid,
            s_axi_bvalid & s_axi_bready};
      r  = s_axi_bresp;
      @(posedge aclk);
      if (hs[3])
        s_axi_awvalid <= 1'b0;
      if (hs[2])
        s_axi_wvalid <= 1'b0;
      if (hs[1] && !hs[0])
        s_axi_bready <= 1'b1;
    end
    s_axi_bready <= 1'b0;
    chk("bresp", er, r);
  endtask : wr

  task automatic rd(input logic [7:0] i, input logic [7:0] e, input logic [1:0] er);
    logic [2:0]  hs;
    logic [31:0] d;
    logic [1:0]  r;
    @(posedge aclk);
    s_axi_araddr  <= {2'h0, i, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= !late;
    hs = 3'h0;
    // Late mode raises rready only once the data is seen waiting
    while (!hs[0]) begin
      @(negedge aclk);
      hs = {s_axi_arvalid & s_axi_arready, s_axi_rvalid, s_axi_rvalid & s_axi_rready};
      d  = s_axi_rdata;
      r  = s_axi_rresp;
      @(posedge aclk);
      if (hs[2])
        s_axi_arvalid <= 1'b0;
      if (hs[1] && !hs[0])
        s_axi_rready <= 1'b1;
    end
    s_axi_rready <= 1'b0;
    chk("rdata", {24'h0, e}, d);
    chk("rresp", er, r);
  endtask : rd

  task automatic snd(input logic [1:0] s, input logic [15:0] pat, input int n, input int code,
                     input logic sc, input logic [2:0] env);
    logic dn;
    @(posedge aclk);
    per       <= BCF << (7 - code);
    sym_sel   <= s;
    sym_start <= 1'b1;
    @(posedge aclk);
    sym_start <= 1'b0;
    dn = 1'b0;
    while (!dn) begin
      @(negedge aclk);
      dn = sym_done;
    end
    chk("nbits", n, m_n);
    chk("bits", pat & ~(16'hffff << n), m_bits);
    chk("cycles", n * per, m_cyc);
    chk("glitch", 0, m_gl);
    chk("subcarrier", sc, tx.subcarrier_848);
    chk("envelope", env, tx.envelope);
    chk("symbol", s, tx.symbol);
  endtask : snd

  task automatic rej(input logic [1:0] s, input logic bv);
    @(posedge aclk);
    sym_sel   <= s;
    sym_start <= 1'b1;
    @(posedge aclk);
    sym_start <= 1'b0;
    @(negedge aclk);
    chk("reject", 1, sym_reject);
    chk("bit_valid", bv, tx.bit_valid);
  endtask : rej

  // Clock
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // Hang guard
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_fail++;
      test_done();
    end
  end

  // Main sequence
  initial begin
    {aresetn, sym_start, sym_sel, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, late} = '0;
    s_axi_wstrb = 4'hf;
    per = BCF;
    {n_fail, checked} = '0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    chk("tx", 0, tx);
    for (int k = 0; k < 10; k++) begin
      rd(idx[k], 8'h00, 2'h0);
      wr(idx[k], 8'hff, 2'h0);
      rd(idx[k], msk[k], 2'h0);
    end
    s_axi_wstrb <= 4'h0;
    wr(idx[0], 8'h00, 2'h0);
    s_axi_wstrb <= 4'hf;
    rd(idx[0], 8'hff, 2'h0);
    late = 1'b1;
    wr(8'h55, 8'h12, 2'h2);
    rd(8'h55, 8'h00, 2'h2);
    late = 1'b0;
    for (int k = 0; k < 10; k++)
      wr(idx[k], cfg[k], 2'h0);
    snd(2'h0, 16'ha53c, 16, 7, 1'b0, 3'h5);
    snd(2'h1, 16'h81f0, 1, 7, 1'b0, 3'h5);
    snd(2'h2, 16'h00c6, 3, 6, 1'b1, 3'h0);
    snd(2'h3, 16'h005a, 4, 6, 1'b1, 3'h0);
    wr(idx[7], 8'hf0, 2'h0);
    for (int c = 2; c < 8; c++) begin
      wr(idx[0], {1'b0, 3'(c), 1'b1, 3'(c)}, 2'h0);
      snd(2'h0, 16'ha53c, 1, c, 1'b1, 3'h5);
      snd(2'h1, 16'h81f0, 16, c, 1'b1, 3'h5);
      snd(2'h2, 16'h00c6, 3, c, 1'b0, 3'h0);
    end
    wr(idx[9], 8'h06, 2'h0);
    fork
      snd(2'h1, 16'h81f0, 16, 7, 1'b1, 3'h0);
      begin
        repeat (3) @(posedge aclk);
        rej(2'h0, 1'b1);
      end
    join
    wr(idx[0], 8'h10, 2'h0);
    rej(2'h0, 1'b0);
    rej(2'h3, 1'b0);
    test_done();
  end
endmodule : tb

bind tsp_symbol_config tsp_symbol_config_assertions chk_u (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .sym_start, .sym_busy,
  .sym_done, .sym_reject, .tx);
